// ==== hdl/lhi_fifo.sv ====
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lhi_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // storage array
    logic [AW-1:0] wr_ptr;           // next slot to fill
    logic [AW-1:0] rd_ptr;           // next slot to drain
    logic [AW:0] count;              // words held
    logic push;
    logic pop;

    // honest flags from the occupancy count
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== hdl/lhi_host_port.sv ====
// host port of the lcd driver: parallel 6800/8080 bus or serial input
`timescale 1ns/1ps
`default_nettype none
module lhi_host_port #(
    parameter int DEPTH = lhi_pkg::LHI_FIFO_DEPTH
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PARALLEL_SELECT,        // high parallel, low serial
    input wire logic BUS_STYLE_SELECT,       // high enable+direction, low strobes
    input wire logic CHIP_SELECT_LOW_N,
    input wire logic CHIP_SELECT_HIGH,
    input wire logic DATA_COMMAND_SELECT,
    input wire logic READ_STROBE,            // read strobe or enable clock
    input wire logic STORE_STROBE,           // write strobe or direction
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic [7:0] DATA_OE,
    input wire logic [7:0] STATUS,           // core status, bit 7 is busy
    input wire logic [7:0] RAM_RDATA,        // ram byte at current address
    output logic RAM_READ_PULSE,             // advance ram read pointer
    output logic ADDR_SETUP_SEEN,            // unused pipeline marker, level
    output logic CORE_VALID,
    input wire logic CORE_READY,
    output logic [7:0] CORE_BYTE,
    output logic CORE_IS_DATA,
    output logic WRITE_DROPPED               // write lost to a full buffer or busy
);
    // two-stage synchronisers for all pins
    // every pin crosses here, so the rest of the block sees one clock only;
    // the cleared chain reads as deselected, so reset brings no false access
    // and no false serial clock edge
    logic [15:0] meta;
    logic [15:0] sync;
    logic ps, c86, cs_n, cs, a0, rd, wr;
    logic [7:0] din;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            meta <= 16'h0000;
            sync <= 16'h0000;
        end else begin
            meta <= {PARALLEL_SELECT, BUS_STYLE_SELECT, CHIP_SELECT_LOW_N, CHIP_SELECT_HIGH,
                     DATA_COMMAND_SELECT, READ_STROBE, STORE_STROBE, 1'b0, DATA_IN};
            sync <= meta;
        end
    end
    assign {ps, c86, cs_n, cs, a0, rd, wr} = sync[15:9];
    assign din = sync[7:0];

    logic sel;  // chip active
    assign sel = !cs_n && cs;

    // parallel access decode
    // the strobe style is read every cycle; switching it in the middle of an
    // access is not supported and may end that access early
    logic p_act;       // a strobe is asserted now
    logic p_read;      // direction of that access
    always_comb begin
        if (c86) begin
            p_act = rd;               // enable clock high
            p_read = wr;              // direction high reads
        end else begin
            p_act = !rd || !wr;
            p_read = !rd;
        end
    end

    lhi_pkg::lhi_state_t state;
    logic p_start;  // first cycle of a selected parallel access
    logic p_end;    // strobe withdrawn
    assign p_start = ps && sel && p_act && (state == lhi_pkg::LHI_IDLE);
    assign p_end = (state == lhi_pkg::LHI_ACT) && (!p_act || !sel);

    // access state machine: read drives bus while active
    // the done state adds one quiet cycle between accesses; a host that
    // spaces its strobes by a few cycles never notices it
    logic cur_read;
    logic cur_a0;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state <= lhi_pkg::LHI_IDLE;
            cur_read <= 1'b0;
            cur_a0 <= 1'b0;
        end else begin
            case (state)
                lhi_pkg::LHI_IDLE: begin
                    if (p_start) begin
                        state <= lhi_pkg::LHI_ACT;
                        cur_read <= p_read;
                        cur_a0 <= a0;
                    end
                end
                lhi_pkg::LHI_ACT: begin
                    if (p_end) begin
                        state <= lhi_pkg::LHI_DONE;
                    end
                end
                lhi_pkg::LHI_DONE: state <= lhi_pkg::LHI_IDLE;
                default: state <= lhi_pkg::LHI_IDLE;
            endcase
        end
    end

    // read pipeline holder: a data read shows the previous fetch
    logic [7:0] holder;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            holder <= lhi_pkg::LHI_BYTE_RST;
            RAM_READ_PULSE <= 1'b0;
            ADDR_SETUP_SEEN <= 1'b0;
        end else begin
            RAM_READ_PULSE <= 1'b0;
            if (p_end && cur_read && cur_a0) begin
                holder <= RAM_RDATA;
                RAM_READ_PULSE <= 1'b1;
                ADDR_SETUP_SEEN <= 1'b0;
            end else if (p_end && !cur_read) begin
                ADDR_SETUP_SEEN <= 1'b1;  // next data read is the dummy
            end
        end
    end

    // bus drive: only during a selected parallel read
    // enable follows the synchronised strobe, so the bus stays driven about
    // three cycles after the host lets go; the host must allow for it
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            DATA_OUT <= lhi_pkg::LHI_BYTE_RST;
            DATA_OE <= 8'h00;
        end else if (ps && sel && (state == lhi_pkg::LHI_ACT) && cur_read && p_act) begin
            DATA_OUT <= cur_a0 ? holder : STATUS;
            DATA_OE <= 8'hff;
        end else begin
            DATA_OE <= 8'h00;
        end
    end

    // serial path: bit 7 data, bit 6 clock
    // the serial clock is only a pin here: its edges are found by the system
    // clock, so each clock phase must last well over two system cycles
    logic scl_d;
    logic scl_rise;
    logic [6:0] shreg;
    logic [2:0] bitcnt;
    assign scl_rise = din[lhi_pkg::LHI_SCL_BIT] && !scl_d;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            scl_d <= 1'b0;
        end else begin
            scl_d <= din[lhi_pkg::LHI_SCL_BIT];
        end
    end

    logic s_byte;  // eighth edge seen this cycle
    logic [7:0] s_word;
    assign s_byte = !ps && sel && scl_rise && (bitcnt == 3'h7);
    assign s_word = {shreg, din[lhi_pkg::LHI_SI_BIT]};
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            shreg <= 7'h00;
            bitcnt <= lhi_pkg::LHI_CNT_RST;
        end else if (ps || !sel) begin
            shreg <= 7'h00;
            bitcnt <= lhi_pkg::LHI_CNT_RST;
        end else if (scl_rise) begin
            shreg <= s_word[6:0];
            bitcnt <= bitcnt + 3'h1;
        end
    end

    // parallel write byte, resampled every active cycle; the last sample
    // before the strobe drops is the one handed on, which spares the data
    // path a second strobe-edge detector
    logic [7:0] holder_w;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            holder_w <= lhi_pkg::LHI_BYTE_RST;
        end else if (state == lhi_pkg::LHI_ACT) begin
            holder_w <= din;
        end
    end

    // bytes toward the core through the buffer
    // a command refused while busy is flagged, not queued, so the core
    // never sees a command out of turn
    logic f_valid;
    logic f_ready;
    logic [8:0] f_data;
    logic p_wr_take;
    assign p_wr_take = p_end && !cur_read && (cur_a0 || !STATUS[lhi_pkg::LHI_BUSY_BIT]);
    always_comb begin
        f_valid = s_byte || p_wr_take;
        if (s_byte) begin
            f_data = {a0, s_word};
        end else begin
            f_data = {cur_a0, holder_w};
        end
    end
    // sixteen words plus the output stage let the host run ahead of the core;
    // a write that finds both full is dropped and flagged
    logic o_valid;
    logic [8:0] o_data;
    lhi_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
        .clk(CLOCK),
        .rst(RST),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data(f_data),
        .out_valid(o_valid),
        .out_ready(!CORE_VALID || CORE_READY),
        .out_data(o_data)
    );

    // registered output stage toward the core
    // it holds byte and flag while the core stalls, as valid/ready requires
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CORE_VALID <= 1'b0;
            CORE_BYTE <= lhi_pkg::LHI_BYTE_RST;
            CORE_IS_DATA <= 1'b0;
            WRITE_DROPPED <= 1'b0;
        end else begin
            if (!CORE_VALID || CORE_READY) begin
                CORE_VALID <= o_valid;
                if (o_valid) begin
                    CORE_BYTE <= o_data[7:0];
                    CORE_IS_DATA <= o_data[8];
                end
            end
            WRITE_DROPPED <= (f_valid && !f_ready) || (p_end && !cur_read && !p_wr_take);
        end
    end

    // checks on the port's own behaviour; all share the system clock and
    // stay quiet while reset is held

    // the bit counter wraps after a full byte
    a_serial_byte_cnt: assert property (@(posedge CLOCK) disable iff (RST)
        (!ps && sel && scl_rise && bitcnt == 3'h7) |=> (bitcnt == 3'h0))
        else $error("bit counter did not wrap at eighth edge");

    // deselect empties the serial state
    a_deselect_clear: assert property (@(posedge CLOCK) disable iff (RST)
        !sel |=> (bitcnt == 3'h0 && shreg == 7'h00))
        else $error("deselect left serial state");

    // no drive in serial mode or while deselected
    a_bus_released: assert property (@(posedge CLOCK) disable iff (RST)
        (!ps || !sel) |=> (DATA_OE == 8'h00))
        else $error("bus driven while not allowed");

    // a status read puts the status byte on the bus
    a_status_read: assert property (@(posedge CLOCK) disable iff (RST)
        (ps && sel && state == lhi_pkg::LHI_ACT && cur_read && p_act && !cur_a0)
        |=> (DATA_OUT == $past(STATUS)))
        else $error("status byte not presented");

    // a data read shows the byte fetched by the read before
    a_data_read: assert property (@(posedge CLOCK) disable iff (RST)
        (ps && sel && state == lhi_pkg::LHI_ACT && cur_read && p_act && cur_a0)
        |=> (DATA_OUT == $past(holder)))
        else $error("data read did not show holder");

    // a finished serial byte goes on with its data flag
    a_serial_push: assert property (@(posedge CLOCK) disable iff (RST)
        s_byte |-> (f_valid && f_data[8] == a0))
        else $error("serial byte not handed on");

    // a parallel access only starts while selected
    a_start_selected: assert property (@(posedge CLOCK) disable iff (RST)
        p_start |-> (sel && ps))
        else $error("access began while deselected");

    // the bus is only driven for a read
    a_oe_in_read: assert property (@(posedge CLOCK) disable iff (RST)
        (DATA_OE != 8'h00) |-> $past(cur_read))
        else $error("bus driven outside a read");

    // a busy core refuses the command and the loss is flagged
    a_busy_cmd_drop: assert property (@(posedge CLOCK) disable iff (RST)
        (p_end && !cur_read && !cur_a0 && STATUS[lhi_pkg::LHI_BUSY_BIT]) |=> WRITE_DROPPED)
        else $error("busy command not flagged as dropped");

    // serial mode never opens a parallel access
    a_serial_no_access: assert property (@(posedge CLOCK) disable iff (RST)
        (!ps && state == lhi_pkg::LHI_IDLE) |=> (state != lhi_pkg::LHI_ACT))
        else $error("parallel access began in serial mode");

    // one fetch per data read
    a_read_pulse_once: assert property (@(posedge CLOCK) disable iff (RST)
        RAM_READ_PULSE |=> !RAM_READ_PULSE)
        else $error("ram read pulse longer than one cycle");

    // a stalled core sees a steady byte
    a_core_hold: assert property (@(posedge CLOCK) disable iff (RST)
        (CORE_VALID && !CORE_READY) |=> (CORE_VALID && $stable(CORE_BYTE) && $stable(CORE_IS_DATA)))
        else $error("core byte changed while stalled");

    // no serial byte right after deselect or in parallel mode
    a_idle_no_byte: assert property (@(posedge CLOCK) disable iff (RST)
        (ps || !sel) |=> !s_byte)
        else $error("serial byte completed while not accepting");
endmodule
`default_nettype wire

// ==== hdl/lhi_pkg.sv ====
// constants shared by the lcd host interface block
// What this block does
// - parallel or serial host path, mode pin picks
// - bus style picks enable+direction or read/write strobes
// - data select high moves display data
// - data select low moves status or commands
// - serial inputs taken only while chip selected
// - serial bits sampled on rising clock, msb first
// - eighth rising clock hands on one byte
// - serial byte is data or command per select
// - data select sampled at every eighth edge
// - deselect clears shift register and bit counter
// - serial mode has no read path
// - interface enabled only when both selects active
// - deselected means bus released, strobes ignored
// - status read shows busy on bit 7
// - first data read after setup returns stale byte
package lhi_pkg;
    localparam int LHI_DATA_W = 8;          // host data bus width
    localparam int LHI_FIFO_DEPTH = 16;     // words held toward the core
    localparam int LHI_SER_BITS = 8;        // serial bits to one byte
    localparam logic [2:0] LHI_CNT_RST = 3'h0;   // bit counter after reset or deselect
    localparam logic [7:0] LHI_BYTE_RST = 8'h00; // read and write holders and output bytes after reset
    localparam int LHI_BUSY_BIT = 7;        // busy position in the status byte
    localparam int LHI_SI_BIT = 7;          // serial data pin in serial mode
    localparam int LHI_SCL_BIT = 6;         // serial clock pin in serial mode
    // access decode states, gray along idle -> active -> done
    typedef enum logic [1:0] {
        LHI_IDLE = 2'b00,
        LHI_ACT = 2'b01,
        LHI_DONE = 2'b11
    } lhi_state_t;
endpackage

// ==== test/lhi_host_model.sv ====
// host microprocessor model driving the lcd host port pins
`timescale 1ns/1ps
`default_nettype none
module lhi_host_model (
    input wire logic clk,
    input wire logic [7:0] dout,
    input wire logic [7:0] doe,
    output logic style,
    output logic cs_n,
    output logic cs,
    output logic dc,
    output logic rd,
    output logic wr,
    output logic [7:0] bus
);
    logic [7:0] drv = 8'h00; // host drive value
    logic [7:0] hoe = 8'h00; // host drive enable, high while driving
    initial begin
        style = 1'b0;
        cs_n = 1'b1;
        cs = 1'b0;
        dc = 1'b0;
        rd = 1'b1;
        wr = 1'b1;
    end
    // wire level; a released line shows the inverse of the last drive, never a kind default
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            bus[i] = hoe[i] ? drv[i] : (doe[i] ? dout[i] : ~drv[i]);
        end
    end
    // both selects together
    task automatic sel(input logic on);
        cs_n = ~on;
        cs = on;
    endtask
    // enable low in 6800 style, strobes high in 8080 style
    task automatic idle();
        rd = ~style;
        wr = 1'b1;
        hoe = 8'h00;
    endtask
    // one bus cycle held seven clocks; read data taken just before release
    task automatic access(input logic rnw, input logic a0, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        dc = a0;
        rd = style | ~rnw;
        wr = rnw;
        drv = d;
        hoe = rnw ? 8'h00 : 8'hff;
        repeat (7) @(posedge clk);
        #1;
        q = bus;
        idle();
        repeat (8) @(posedge clk);
        #1;
    endtask
    // msb first on bit 7, clock on bit 6 rising mid-bit, clock rests low
    task automatic ser_bits(input logic [7:0] d, input int n);
        hoe = 8'hc0;
        for (int i = 7; i > 7 - n; i--) begin
            drv[7] = d[i];
            #62.5 drv[6] = 1'b1;
            #62.5 drv[6] = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== test/lhi_host_port_tb_top.sv ====
// self-checking bench for the lcd host port
`timescale 1ns/1ps
`default_nettype none
module lhi_host_port_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic par; // parallel mode pin, set at time zero
    logic core_ready;
    logic [7:0] status;
    logic [7:0] ram;
    logic style, cs_n, cs, dc, rd, wr, ram_pulse, setup_seen, core_valid, core_is_data, dropped;
    logic [7:0] bus, dout, doe, core_byte;
    logic [8:0] got[$]; // bytes toward the core, data flag on top
    int drops = 0;
    int pulses = 0;
    int serial_oe = 0;
    int err_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    lhi_host_port #(.DEPTH(16)) dut (.CLOCK(clk), .RST(rst), .PARALLEL_SELECT(par), .BUS_STYLE_SELECT(style),
        .CHIP_SELECT_LOW_N(cs_n), .CHIP_SELECT_HIGH(cs), .DATA_COMMAND_SELECT(dc), .READ_STROBE(rd),
        .STORE_STROBE(wr), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(doe), .STATUS(status), .RAM_RDATA(ram),
        .RAM_READ_PULSE(ram_pulse), .ADDR_SETUP_SEEN(setup_seen), .CORE_VALID(core_valid),
        .CORE_READY(core_ready), .CORE_BYTE(core_byte), .CORE_IS_DATA(core_is_data), .WRITE_DROPPED(dropped));
    lhi_host_model host (.clk(clk), .dout(dout), .doe(doe), .style(style), .cs_n(cs_n), .cs(cs), .dc(dc),
        .rd(rd), .wr(wr), .bus(bus));
    // monitor: collect handed-on bytes and count one-cycle pulses
    always @(posedge clk) begin
        if (core_valid === 1'b1 && core_ready === 1'b1) got.push_back({core_is_data, core_byte});
        if (dropped === 1'b1) drops++;
        if (ram_pulse === 1'b1) pulses++;
        if (par === 1'b0 && doe !== 8'h00) serial_oe++;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for the next byte; none at all leaves unknown and fails
    task automatic take(input logic [8:0] exp);
        logic [8:0] v;
        v = 'x;
        for (int i = 0; i < 40 && got.size() == 0; i++) @(posedge clk);
        if (got.size() > 0) v = got.pop_front();
        check(v, exp);
    endtask
    task automatic end_of_test();
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        logic [7:0] q;
        int d0;
        par = 1'b1;
        core_ready = 1'b1;
        status = 8'h00;
        ram = 8'h00;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        check({dropped, doe}, 9'h000);
        host.sel(1'b1);
        // both bus styles: data write, command write, status read
        for (int s = 0; s < 2; s++) begin
            host.style = s[0];
            host.idle();
            status = 8'h05 + 8'(s);
            host.access(1'b0, 1'b1, 8'ha5 + 8'(s), q);
            take({1'b1, 8'ha5 + 8'(s)});
            host.access(1'b0, 1'b0, 8'h3c + 8'(s), q);
            take({1'b0, 8'h3c + 8'(s)});
            host.access(1'b1, 1'b0, 8'h00, q);
            check({1'b0, q}, {1'b0, status});
        end
        // busy: status shows bit 7, command dropped
        status = 8'h85;
        host.access(1'b1, 1'b0, 8'h00, q);
        check({1'b0, q}, 9'h085);
        d0 = drops;
        host.access(1'b0, 1'b0, 8'h11, q);
        check(9'(drops - d0), 9'h001);
        check(9'(got.size()), 9'h000);
        status = 8'h00;
        // data reads lag one fetch behind
        d0 = pulses;
        ram = 8'h61;
        check({8'h00, setup_seen}, 9'h001);
        host.access(1'b1, 1'b1, 8'h00, q);
        check({1'b0, q}, {1'b0, lhi_pkg::LHI_BYTE_RST});
        check({8'h00, setup_seen}, 9'h000);
        ram = 8'h62;
        host.access(1'b1, 1'b1, 8'h00, q);
        check({1'b0, q}, 9'h061);
        host.access(1'b1, 1'b1, 8'h00, q);
        check({1'b0, q}, 9'h062);
        check(9'(pulses - d0), 9'h003);
        // deselected: write ignored, bus left floating
        host.sel(1'b0);
        host.access(1'b0, 1'b1, 8'h77, q);
        host.access(1'b1, 1'b0, 8'h0f, q);
        check({1'b0, q}, 9'h0f0);
        check(9'(got.size()), 9'h000);
        // serial: two bytes in one selection, then a partial byte cut by deselect
        par = 1'b0;
        host.drv = 8'h00;
        repeat (5) @(posedge clk);
        #1 host.sel(1'b1);
        host.dc = 1'b1;
        host.ser_bits(8'hb4, 8);
        host.dc = 1'b0;
        host.ser_bits(8'h2d, 8);
        take(9'h1b4);
        take(9'h02d);
        host.ser_bits(8'hff, 3);
        host.sel(1'b0);
        host.ser_bits(8'h55, 8);
        #200 host.sel(1'b1);
        host.dc = 1'b1;
        host.ser_bits(8'h81, 8);
        take(9'h181);
        check(9'(got.size() + serial_oe), 9'h000);
        // buffer: fill with the core stalled until writes are refused, then drain
        par = 1'b1;
        host.idle();
        core_ready = 1'b0;
        d0 = drops;
        for (int i = 0; i < 18; i++) host.access(1'b0, 1'b1, 8'(i), q);
        core_ready = 1'b1;
        repeat (60) @(posedge clk);
        check({8'h00, got.size() >= 16}, 9'h001);
        check(9'(drops - d0 + got.size()), 9'h012);
        for (int i = 0; i < got.size(); i++) check(got[i], {1'b1, 8'(i)});
        end_of_test();
    end
    // watchdog well beyond the expected run of some 10 us
    initial begin
        #300000;
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
